// file: cmp2_defines.svh
// Offsets, field positions, reset values and timing counts for the comparator control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CMP2_DEFINES_SVH
`define CMP2_DEFINES_SVH
`define CMP2_ADDR_W          4
`define CMP2_OFS_STATUS      4'h3
`define CMP2_OFS_CMP1_CTRL   4'h7
`define CMP2_OFS_CMP2_CTRL   4'h8
`define CMP2_OFS_PIN_DIR     4'h6
`define CMP2_BIT_RESULT      7
`define CMP2_BIT_DRIVE_N     6
`define CMP2_BIT_POLARITY    5
`define CMP2_BIT_POS_HI      4
`define CMP2_BIT_ON          3
`define CMP2_BIT_NEG_SEL     2
`define CMP2_BIT_POS_LO      1
`define CMP2_BIT_WAKE_DIS    0
`define CMP2_ST_PIN_WAKE     7
`define CMP2_ST_CMP_WAKE     6
`define CMP2_ST_PAGE         5
`define CMP2_ST_TIMEOUT      4
`define CMP2_ST_POWERDOWN    3
`define CMP2_CTRL_POR        7'h7F
`define CMP2_STATUS_POR      8'h18
`define CMP2_PIN_DIR_POR     6'h3F
`define CMP2_UNMAPPED_DATA   32'h0000_0000
`define CMP2_WAIT_CYCLES     1
`endif

// file: cmp2_pkg.sv
// Types shared by the comparator control block.
// Assumes cmp2_defines.svh is in the include path.
`include "cmp2_defines.svh"
package cmp2_pkg;
	typedef enum logic [1:0] {
		CMP2_IDLE = 2'b01,
		CMP2_ACK  = 2'b00
	} cmp2_bus_state_type;

	typedef struct packed {
		logic [`CMP2_ADDR_W-1:0] address;
		logic                    read;
		logic                    write;
		logic [31:0]             writedata;
	} cmp2_avm_req_type;

	typedef struct packed {
		logic       pin_wake;
		logic       cmp_wake;
		logic       wdt_reset;
		logic       master_clear;
		logic       sleeping;
	} cmp2_event_type;

	typedef struct packed {
		cmp2_bus_state_type bus_state;
		logic [31:0]        readdata;
		logic [7:0]         status;
		logic [6:0]         cmp1_ctrl;
		logic [6:0]         cmp2_ctrl;
		logic [5:0]         pin_dir;
		logic [1:0]         result_sync;
		logic               result;
		logic               pin_out;
		logic               pin_oe_n;
		logic               powered;
		logic               neg_sel;
		logic [1:0]         pos_sel;
		logic               wake_armed;
	} cmp2_state_type;
endpackage

// file: cmp2_ctrl.sv
// Control and status registers of the second comparator and the core status flags.
// Assumes an Avalon-MM master on clk_in, the analogue comparator outside, and
// reset causes delivered as one-cycle pulses from logic on the same clock.
// Summary of operation
// - Polarity bit one passes result, zero inverts.
// - Drive bit one keeps result off the pin.
// - Comparator powered only while enable bit is one.
// - Negative select: one pin, zero internal reference.
// - Polarity, reference, wake bits act only when enabled.
// - Power-on loads ones; other resets keep bits.
// - Comparator wake sets pattern 0101 0uuu.
// - Pin wake sets pattern 1001 0uuu.
// - Watchdog reset in sleep gives 0000 0uuu.
// - Watchdog reset running gives 0000 uuuu.
// - Master clear in sleep gives 0001 0uuu.
// - Master clear running gives 000u uuuu.
//
// Register map, one 8-bit register per word index, upper bytes read zero:
// index 3 core_status_flags, index 6 pin_direction_control,
// index 7 comparator_one_control, index 8 comparator_two_control.
// Control bit 7 is the live result at index 8, reads zero at index 7, and ignores writes; a power-on reset
// loads the other seven bits with ones, every later reset cause leaves them.
// The bus state encoding keeps bit 0 equal to waitrequest, so the stall
// output is a flip-flop and not a decoder that could glitch.
`timescale 1ns/1ps
`default_nettype none
`include "cmp2_defines.svh"
module cmp2_ctrl
	import cmp2_pkg::*;
(
	input  wire logic                    clk_in,            // Core clock, 100 MHz.
	input  wire logic                    reset_in,          // Power-on reset, async high.
	input  wire logic [`CMP2_ADDR_W-1:0] avs_address_in,    // Register index.
	input  wire logic                    avs_read_in,       // Read request.
	input  wire logic                    avs_write_in,      // Write request.
	input  wire logic [31:0]             avs_writedata_in,  // Write data.
	input  wire logic [3:0]              avs_byteenable_in, // Byte lanes.
	output logic      [31:0]             avs_readdata_out,  // Read data.
	output logic                         avs_waitrequest_out, // Stall.
	input  wire logic                    cmp_raw_in,        // Analogue decision pin.
	input  wire logic                    pin_wake_in,       // Pin change wake pulse.
	input  wire logic                    cmp_wake_in,       // Comparator wake pulse.
	input  wire logic                    wdt_reset_in,      // Watchdog reset pulse.
	input  wire logic                    master_clear_in,   // Master clear pulse.
	input  wire logic                    sleeping_in,       // Core is in sleep.
	output logic                         cmp_powered_out,   // Comparator power on.
	output logic                         cmp_neg_sel_out,   // 1 neg pin, 0 vref.
	output logic      [1:0]              cmp_pos_sel_out,   // Positive input choice.
	output logic                         cmp_wake_arm_out,  // Wake on change armed.
	output logic                         cmp_pin_out,       // Output pin level.
	output logic                         cmp_pin_oe_n_out   // Output enable, low drives.
);
	cmp2_state_type   cur_ff;
	cmp2_state_type   nxt_ff;
	cmp2_avm_req_type req;
	cmp2_event_type   evt;
	logic             polarized;
	logic [7:0]       ctrl_read;
	logic [7:0]       st_mask;

	assign req = '{address: avs_address_in, read: avs_read_in,
		write: avs_write_in, writedata: avs_writedata_in};
	assign evt = '{pin_wake: pin_wake_in, cmp_wake: cmp_wake_in,
		wdt_reset: wdt_reset_in, master_clear: master_clear_in,
		sleeping: sleeping_in};

	always_comb begin
		nxt_ff = cur_ff;
		polarized = 1'b0;
		ctrl_read = 8'h00;
		st_mask = 8'h00;
		// The comparator output is asynchronous to the core clock.
		nxt_ff.result_sync = {cur_ff.result_sync[0], cmp_raw_in};
		polarized = cur_ff.result_sync[1];
		if (cur_ff.cmp2_ctrl[`CMP2_BIT_ON]) begin
			if (!cur_ff.cmp2_ctrl[`CMP2_BIT_POLARITY]) begin
				polarized = ~cur_ff.result_sync[1];
			end
		end
		nxt_ff.result = polarized;
		nxt_ff.powered = cur_ff.cmp2_ctrl[`CMP2_BIT_ON];
		// When off, shared pins fall back to their other owners, so the
		// selects drop to defaults and the pin is released.
		nxt_ff.neg_sel = cur_ff.cmp2_ctrl[`CMP2_BIT_ON] &
			cur_ff.cmp2_ctrl[`CMP2_BIT_NEG_SEL];
		nxt_ff.pos_sel = cur_ff.cmp2_ctrl[`CMP2_BIT_ON] ?
			{cur_ff.cmp2_ctrl[`CMP2_BIT_POS_HI],
			 cur_ff.cmp2_ctrl[`CMP2_BIT_POS_LO]} : 2'b00;
		nxt_ff.wake_armed = cur_ff.cmp2_ctrl[`CMP2_BIT_ON] &
			~cur_ff.cmp2_ctrl[`CMP2_BIT_WAKE_DIS];
		nxt_ff.pin_oe_n = ~(cur_ff.cmp2_ctrl[`CMP2_BIT_ON] &
			~cur_ff.cmp2_ctrl[`CMP2_BIT_DRIVE_N]);
		nxt_ff.pin_out = polarized;

		// Bus slave: one wait cycle, then answer.
		case (cur_ff.bus_state)
			CMP2_IDLE: begin
				if (req.read || req.write) begin
					nxt_ff.bus_state = CMP2_ACK;
				end
			end
			CMP2_ACK: begin
				nxt_ff.bus_state = CMP2_IDLE;
			end
			default: begin
				nxt_ff.bus_state = CMP2_IDLE;
			end
		endcase
		ctrl_read = {cur_ff.result, cur_ff.cmp2_ctrl};
		if (cur_ff.bus_state == CMP2_IDLE && req.read) begin
			if (req.address == `CMP2_OFS_STATUS) begin
				nxt_ff.readdata = {24'h000000, cur_ff.status};
			end else if (req.address == `CMP2_OFS_CMP2_CTRL) begin
				nxt_ff.readdata = {24'h000000, ctrl_read};
			end else if (req.address == `CMP2_OFS_CMP1_CTRL) begin
				nxt_ff.readdata = {24'h000000, 1'b0, cur_ff.cmp1_ctrl};
			end else if (req.address == `CMP2_OFS_PIN_DIR) begin
				nxt_ff.readdata = {26'h0, cur_ff.pin_dir};
			end else begin
				nxt_ff.readdata = `CMP2_UNMAPPED_DATA;
			end
		end
		if (cur_ff.bus_state == CMP2_ACK && req.write &&
			avs_byteenable_in[0]) begin
			if (req.address == `CMP2_OFS_STATUS) begin
				// Time-out and power-down are read-only to software.
				nxt_ff.status = {req.writedata[7:5], cur_ff.status[4:3],
					req.writedata[2:0]};
			end else if (req.address == `CMP2_OFS_CMP2_CTRL) begin
				nxt_ff.cmp2_ctrl = req.writedata[6:0];
			end else if (req.address == `CMP2_OFS_CMP1_CTRL) begin
				nxt_ff.cmp1_ctrl = req.writedata[6:0];
			end else if (req.address == `CMP2_OFS_PIN_DIR) begin
				nxt_ff.pin_dir = req.writedata[5:0];
			end
		end

		// Reset and wake causes override software writes in the same cycle;
		// the control bits keep their values on all of them.
		st_mask = cur_ff.status;
		if (evt.master_clear) begin
			st_mask[`CMP2_ST_PIN_WAKE] = 1'b0;
			st_mask[`CMP2_ST_CMP_WAKE] = 1'b0;
			st_mask[`CMP2_ST_PAGE] = 1'b0;
			if (evt.sleeping) begin
				st_mask[`CMP2_ST_TIMEOUT] = 1'b1;
				st_mask[`CMP2_ST_POWERDOWN] = 1'b0;
			end
			nxt_ff.status = st_mask;
		end else if (evt.wdt_reset) begin
			st_mask[7:4] = 4'h0;
			if (evt.sleeping) begin
				st_mask[`CMP2_ST_POWERDOWN] = 1'b0;
			end
			nxt_ff.status = st_mask;
		end else if (evt.pin_wake && evt.sleeping) begin
			st_mask[7:3] = 5'h12;
			nxt_ff.status = st_mask;
		end else if (evt.cmp_wake && evt.sleeping && cur_ff.wake_armed) begin
			st_mask[7:3] = 5'h0A;
			nxt_ff.status = st_mask;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cur_ff.bus_state   <= CMP2_IDLE;
			cur_ff.readdata    <= 32'h0000_0000;
			cur_ff.status      <= `CMP2_STATUS_POR;
			cur_ff.cmp1_ctrl   <= `CMP2_CTRL_POR;
			cur_ff.cmp2_ctrl   <= `CMP2_CTRL_POR;
			cur_ff.pin_dir     <= `CMP2_PIN_DIR_POR;
			cur_ff.result_sync <= 2'b00;
			cur_ff.result      <= 1'b0;
			cur_ff.pin_out     <= 1'b0;
			cur_ff.pin_oe_n    <= 1'b1;
			cur_ff.powered     <= 1'b0;
			cur_ff.neg_sel     <= 1'b0;
			cur_ff.pos_sel     <= 2'b00;
			cur_ff.wake_armed  <= 1'b0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign avs_readdata_out    = cur_ff.readdata;
	assign avs_waitrequest_out = cur_ff.bus_state[0];
	assign cmp_powered_out     = cur_ff.powered;
	assign cmp_neg_sel_out     = cur_ff.neg_sel;
	assign cmp_pos_sel_out     = cur_ff.pos_sel;
	assign cmp_wake_arm_out    = cur_ff.wake_armed;
	assign cmp_pin_out         = cur_ff.pin_out;
	assign cmp_pin_oe_n_out    = cur_ff.pin_oe_n;
endmodule
`default_nettype wire

// file: cmp2_ctrl_monitor.sv
// Assertions on the ports of the comparator control block.
// Assumes binding into every cmp2_ctrl instance on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmp2_defines.svh"
module cmp2_ctrl_monitor
	import cmp2_pkg::*;
(
	input wire logic [3:0]  avs_byteenable_in,   // Lanes.
	input wire logic        clk_in,              // Clock.
	input wire logic        reset_in,            // Reset.
	input wire logic [3:0]  avs_address_in,      // Index.
	input wire logic        avs_read_in,         // Read.
	input wire logic        avs_write_in,        // Write.
	input wire logic [31:0] avs_writedata_in,    // Data.
	input wire logic        avs_waitrequest_out, // Stall.
	input wire logic        cmp_powered_out,     // Power.
	input wire logic        cmp_neg_sel_out,     // Neg select.
	input wire logic [1:0]  cmp_pos_sel_out,     // Pos select.
	input wire logic        cmp_wake_arm_out,    // Wake armed.
	input wire logic        cmp_pin_oe_n_out     // Pin enable.
);
	logic [7:0] wd1_ff;
	logic [7:0] wd2_ff;
	always_ff @(posedge clk_in) begin
		wd1_ff <= avs_writedata_in[7:0];
		wd2_ff <= wd1_ff;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_wr;
		avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& avs_address_in == `CMP2_OFS_CMP2_CTRL;
	endsequence
	a_power_follow: assert property (s_wr |-> ##2
		cmp_powered_out == wd2_ff[3]) else $error("power mismatch");
	a_negsel_follow: assert property (s_wr |-> ##2
		cmp_neg_sel_out == (wd2_ff[3] & wd2_ff[2])) else $error("neg mismatch");
	a_possel_follow: assert property (s_wr |-> ##2
		cmp_pos_sel_out == (wd2_ff[3] ? {wd2_ff[4], wd2_ff[1]} : 2'h0))
		else $error("pos mismatch");
	a_arm_follow: assert property (s_wr |-> ##2
		cmp_wake_arm_out == (wd2_ff[3] & ~wd2_ff[0])) else $error("arm mismatch");
	a_drive_follow: assert property (s_wr |-> ##2
		cmp_pin_oe_n_out == ~(wd2_ff[3] & ~wd2_ff[6])) else $error("drive bad");
	a_off_quiet: assert property (!cmp_powered_out |-> cmp_pin_oe_n_out
		&& !cmp_wake_arm_out && !cmp_neg_sel_out && cmp_pos_sel_out == 2'h0)
		else $error("off outputs bad");
	a_reset_values: assert property ($fell(reset_in) |-> ##1 cmp_powered_out
		&& cmp_neg_sel_out && cmp_pos_sel_out == 2'h3 && cmp_pin_oe_n_out)
		else $error("reset outputs bad");
	a_wait_answer: assert property ((avs_read_in || avs_write_in)
		&& avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out)
		else $error("no bus answer");
endmodule
bind cmp2_ctrl cmp2_ctrl_monitor cmp2_ctrl_monitor_inst (.clk_in(clk_in),
	.reset_in(reset_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_waitrequest_out(avs_waitrequest_out), .cmp_powered_out(cmp_powered_out),
	.cmp_neg_sel_out(cmp_neg_sel_out), .cmp_pos_sel_out(cmp_pos_sel_out),
	.cmp_wake_arm_out(cmp_wake_arm_out), .cmp_pin_oe_n_out(cmp_pin_oe_n_out));
`default_nettype wire

// file: cmp2_analog_model.sv
// Behavioural analogue comparator beside the control block.
// Assumes selects from cmp2_ctrl and pin levels from the bench.
`timescale 1ns/1ps
`default_nettype none
module cmp2_analog_model #(
	parameter logic [7:0] VREF = 8'h40, // Internal reference level.
	parameter logic [7:0] ALT  = 8'h20  // Alternate positive pin level.
) (
	input  wire logic       clk_in,  // Clock.
	input  wire logic       on_in,   // Power.
	input  wire logic       neg_in,  // Neg select.
	input  wire logic [1:0] pos_in,  // Pos select.
	input  wire logic [7:0] vpos_in, // Positive pin.
	input  wire logic [7:0] vneg_in, // Negative pin.
	output logic            raw_out  // Decision.
);
	// Unpowered, the decision means nothing, so it wanders on purpose.
	always_ff @(posedge clk_in) begin
		if (on_in) begin
			raw_out <= (pos_in[1] ? ALT : vpos_in) > (neg_in ? vneg_in : VREF);
		end else begin
			raw_out <= ~raw_out;
		end
	end
endmodule
`default_nettype wire

// file: cmp2_ctrl_test.sv
// Self-checking bench for the comparator control block.
// Assumes the analogue model feeds the decision pin; one clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmp2_defines.svh"
module cmp2_ctrl_test
	import cmp2_pkg::*;
;
	logic             clk_in = 1'b0;
	logic             reset_in = 1'b1;
	cmp2_avm_req_type req = '0;
	cmp2_event_type   ev = '0;
	logic [31:0]      rdata, q;
	logic             waitreq, raw, on, neg, arm, pin, oe_n;
	logic [1:0]       pos;
	logic [2:0]       k;
	int               failures = 0, total_checks = 0, cycles = 0;
	logic [7:0] row_wd [8] = '{8'h37, 8'h68, 8'h28, 8'h3C, 8'h2C, 8'h38,
		8'h2B, 8'h08};
	logic [6:0] row_exp [8] = '{7'h02, 7'h47, 7'h45, 7'h75, 7'h65, 7'h54,
		7'h49, 7'h44};
	logic [3:0] ev_row [9] = '{4'h0, 4'h2, 4'h7, 4'h9, 4'h5, 4'h0, 4'h4,
		4'h0, 4'h3};
	logic [7:0] ev_exp [9] = '{8'hFF, 8'h1F, 8'h97, 8'h57, 8'h07, 8'hE7,
		8'h07, 8'hE7, 8'h17};
	cmp2_ctrl cmp2_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in),
		.avs_address_in(req.address), .avs_read_in(req.read),
		.avs_write_in(req.write), .avs_writedata_in(req.writedata),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .cmp_raw_in(raw),
		.pin_wake_in(ev.pin_wake), .cmp_wake_in(ev.cmp_wake),
		.wdt_reset_in(ev.wdt_reset), .master_clear_in(ev.master_clear),
		.sleeping_in(ev.sleeping), .cmp_powered_out(on), .cmp_neg_sel_out(neg),
		.cmp_pos_sel_out(pos), .cmp_wake_arm_out(arm), .cmp_pin_out(pin),
		.cmp_pin_oe_n_out(oe_n));
	cmp2_analog_model cmp2_analog_model_inst (.clk_in(clk_in), .on_in(on),
		.neg_in(neg), .pos_in(pos), .vpos_in(8'h80), .vneg_in(8'h10),
		.raw_out(raw));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		req <= '{a, !wr, wr, {24'h0, d}};
		do @(posedge clk_in); while (waitreq !== 1'b0);
		q = rdata;
		req <= '0;
		@(posedge clk_in);
	endtask
	task automatic por_check();
		bus(1'b0, `CMP2_OFS_CMP2_CTRL, 8'h00);
		chk("ctrl reset", 32'h7F, q & 32'hFFFFFF7F);
		bus(1'b0, `CMP2_OFS_STATUS, 8'h00);
		chk("status reset", 32'h18, q & 32'hFFFFFFF8);
		bus(1'b0, `CMP2_OFS_CMP1_CTRL, 8'h00);
		chk("cmp1 reset", 32'h7F, q & 32'hFFFFFF7F);
		bus(1'b0, `CMP2_OFS_PIN_DIR, 8'h00);
		chk("pin dir reset", 32'h3F, q);
		bus(1'b1, `CMP2_OFS_PIN_DIR, 8'h15);
		bus(1'b0, `CMP2_OFS_PIN_DIR, 8'h00);
		chk("pin dir", 32'h15, q);
		bus(1'b1, 4'hF, 8'h5A);
		bus(1'b0, 4'hF, 8'h00);
		chk("unmapped", 32'h0, q);
		$display("test reset values done");
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		por_check();
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, `CMP2_OFS_CMP2_CTRL, row_wd[i]);
			repeat (8) @(posedge clk_in);
			chk("outputs", {25'h0, row_exp[i]}, {25'h0, on, neg, pos, arm, oe_n,
				oe_n ? row_exp[i][0] : pin});
			bus(1'b0, `CMP2_OFS_CMP2_CTRL, 8'h00);
			chk("ctrl read", {24'h0, row_exp[i][0], row_wd[i][6:0]}, {24'h0,
				on ? q[7] : row_exp[i][0], q[6:0]});
		end
		$display("test control rows done");
		for (int i = 0; i < 9; i++) begin
			k = ev_row[i][3:1];
			if (k == 3'h0) begin
				bus(1'b1, `CMP2_OFS_STATUS, 8'hE7);
			end else begin
				ev <= {k == 3'h3, k == 3'h4, k == 3'h2, k == 3'h1, ev_row[i][0]};
				@(posedge clk_in);
				ev <= '0;
				@(posedge clk_in);
			end
			bus(1'b0, `CMP2_OFS_STATUS, 8'h00);
			chk("status", {24'h0, ev_exp[i]}, q);
		end
		bus(1'b0, `CMP2_OFS_CMP2_CTRL, 8'h00);
		chk("ctrl kept", 32'h08, q & 32'h7F);
		$display("test status events done");
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		por_check();
		print_verdict();
	end
endmodule
`default_nettype wire
